//--- core/srxo_mapper.sv
`timescale 1ns/1ps
//==========================================================
// combinational bit placement onto the output bus
//==========================================================
module srxo_mapper
    import srxo_pkg::*;
(
    input wire srxo_pkg::srxo_mode_t mode,
    input wire logic [srxo_pkg::RAW_W-1:0] rawBits,
    input wire logic [srxo_pkg::DATA10_W-1:0] decodedData,
    input wire logic [srxo_pkg::CMD_W-1:0] decodedCmd,
    input wire logic isCommand,
    output logic [srxo_pkg::BUS_W-1:0] busBits,
    output logic [1:0] cmdPins
);
    // pick bus contents per decoder mode
    always_comb begin
        busBits = BUS_RESET;
        cmdPins = CMDPIN_RESET;
        unique case (mode)
            SRXO_ENC8: begin
                if (isCommand) begin
                    busBits[BUS_CMD3] = decodedCmd[3];
                    busBits[BUS_CMD2] = decodedCmd[CMD_HI_LSB];
                    cmdPins = decodedCmd[1:0];
                end else begin
                    busBits[DATA8_W-1:0] = decodedData[DATA8_W-1:0];
                end
            end
            SRXO_ENC10: begin
                if (isCommand) begin
                    cmdPins = decodedCmd[1:0];
                end else begin
                    busBits = decodedData;
                end
            end
            SRXO_RAW10: begin
                busBits = rawBits[BUS_W-1:0];
            end
            SRXO_RAW12: begin
                busBits = rawBits[BUS_W-1:0];
                cmdPins = {rawBits[RAW_B10], rawBits[RAW_B11]};
            end
        endcase
    end
endmodule

//--- core/srxo_pkg.sv
//==========================================================
// receive output port constants
//==========================================================
// Overview of operation
// - select then read strobe next cycle enables bus
// - bit placement follows bypass and width selects, fifo select picks the source only in codec bypass
// - fifo and codec bypass pass characters straight through
// - framing on with sync gives aligned characters
// - framing off or no sync may misalign
// - encoded 8-bit: data 7..0, command on 8,9,pins
// - encoded 10-bit: data 9..0 or command bits 1,0
// - bypass width high: raw bits 0..9 ascending
// - bypass width low: raw 0..9, 11, 10
// - first received bit lands at raw position 0
// - output register updates on rising clock only
package srxo_pkg;
    localparam int RAW_W = 12;
    localparam int BUS_W = 10;
    localparam int CMD_W = 4;
    localparam int DATA8_W = 8;
    localparam int DATA10_W = 10;
    localparam int CMD_HI_LSB = 2; // command bits 3,2 go to bus 8,9
    localparam int BUS_CMD3 = 8;
    localparam int BUS_CMD2 = 9;
    localparam int RAW_B10 = 10;
    localparam int RAW_B11 = 11;
    localparam logic [BUS_W-1:0] BUS_RESET = 10'h000;
    localparam logic [1:0] CMDPIN_RESET = 2'h0;
    localparam int DR_FRAMING = 1;
    localparam int DR_PAYLOAD = 0;
    localparam int DR_CODED = 2;
    typedef enum logic [1:0] {
        SRXO_ENC8,
        SRXO_ENC10,
        SRXO_RAW10,
        SRXO_RAW12
    } srxo_mode_t;
    typedef enum {
        SRXO_IDLE,
        SRXO_ADDRESSED,
        SRXO_READING
    } srxo_state_t;
endpackage

//--- core/srxo_port.sv
`timescale 1ns/1ps
//==========================================================
// receive output port top
//==========================================================
module srxo_port
    import srxo_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic chipSelect_n,
    input wire logic rx_read_strobe,
    input wire logic codec_bypass_n,
    input wire logic char_width_sel,
    input wire logic fifo_bypass_sel,
    input wire logic frame_align_enable,
    input wire logic syncSeen,
    input wire logic fifoValid,
    input wire logic [srxo_pkg::RAW_W-1:0] fifoRaw,
    input wire logic [srxo_pkg::DATA10_W-1:0] fifoData,
    input wire logic [srxo_pkg::CMD_W-1:0] fifoCmd,
    input wire logic fifoIsCmd,
    input wire logic fifoViolation,
    input wire logic deserValid,
    input wire logic [srxo_pkg::RAW_W-1:0] deserRaw,
    output logic fifoRead,
    output logic [srxo_pkg::BUS_W-1:0] rx_char_bus,
    output logic [1:0] rx_command_bits,
    output logic rx_cmd_data_flag,
    output logic code_violation,
    output logic busOe_n,
    output logic charValid,
    output logic aligned
);
    srxo_state_t state;
    srxo_mode_t mode;
    logic passThrough;
    logic coded;
    logic srcValid;
    logic [RAW_W-1:0] srcRaw;
    logic [BUS_W-1:0] mapBus;
    logic [1:0] mapCmd;

    // decode the selected mode from the two strap inputs, bypass and width
    function automatic srxo_mode_t decode_mode(input logic bypN, input logic w8);
        if (bypN) decode_mode = w8 ? SRXO_ENC8 : SRXO_ENC10;
        else decode_mode = w8 ? SRXO_RAW10 : SRXO_RAW12;
    endfunction

    assign mode = decode_mode(codec_bypass_n, char_width_sel);
    assign coded = codec_bypass_n;
    // fifo and decoder both bypassed: deserializer feeds the register
    assign passThrough = fifo_bypass_sel && !codec_bypass_n;
    assign srcValid = passThrough ? deserValid : fifoValid;
    assign srcRaw = passThrough ? deserRaw : fifoRaw;

    srxo_mapper srxo_mapper_inst (
        .mode(mode),
        .rawBits(srcRaw),
        .decodedData(fifoData),
        .decodedCmd(fifoCmd),
        .isCommand(fifoIsCmd),
        .busBits(mapBus),
        .cmdPins(mapCmd)
    );

    // select-then-strobe sequencing
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= SRXO_IDLE;
        end else begin
            unique case (state)
                SRXO_IDLE: if (!chipSelect_n) state <= SRXO_ADDRESSED;
                SRXO_ADDRESSED: begin
                    if (rx_read_strobe) state <= SRXO_READING;
                    else if (chipSelect_n) state <= SRXO_IDLE;
                end
                SRXO_READING: if (!rx_read_strobe) begin
                    state <= chipSelect_n ? SRXO_IDLE : SRXO_ADDRESSED;
                end
            endcase
        end
    end

    // bus drivers on while reading, fifo read pulses with them except in passthrough
    always_ff @(posedge clock) begin
        if (reset) begin
            busOe_n <= 1'b1;
            fifoRead <= 1'b0;
        end else begin
            busOe_n <= !(rx_read_strobe &&
                (state == SRXO_ADDRESSED || state == SRXO_READING));
            fifoRead <= rx_read_strobe && !passThrough &&
                (state == SRXO_ADDRESSED || state == SRXO_READING);
        end
    end

    // output register, rising edge only
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_char_bus <= BUS_RESET;
            rx_command_bits <= CMDPIN_RESET;
            rx_cmd_data_flag <= 1'b0;
            code_violation <= 1'b0;
            charValid <= 1'b0;
        end else begin
            charValid <= srcValid;
            if (srcValid) begin
                rx_char_bus <= mapBus;
                rx_command_bits <= mapCmd;
                rx_cmd_data_flag <= coded && fifoIsCmd;
                code_violation <= coded && fifoViolation;
            end
        end
    end

    // aligned only with framing on and sync seen
    always_ff @(posedge clock) begin
        if (reset) aligned <= 1'b0;
        else aligned <= frame_align_enable && syncSeen;
    end

    // host does its own framing when this is low in bypass

    // ======================================================
    // select and strobe checks
    // ======================================================
    select_taken_a: assert property (
        @(posedge clock) disable iff (reset)
        (state == SRXO_IDLE && !chipSelect_n) |=> state == SRXO_ADDRESSED)
        else $error("selection not taken");
    oe_follows_a: assert property (
        @(posedge clock) disable iff (reset)
        (state == SRXO_ADDRESSED && rx_read_strobe) |=> !busOe_n)
        else $error("bus drivers not enabled after strobe");
    oe_idle_a: assert property (
        @(posedge clock) disable iff (reset)
        (state == SRXO_IDLE) |=> busOe_n)
        else $error("bus driven without selection");
    read_start_a: assert property (
        @(posedge clock) disable iff (reset)
        (state == SRXO_ADDRESSED && rx_read_strobe && !passThrough) |=> fifoRead)
        else $error("fifo read not started");
    stray_read_a: assert property (
        @(posedge clock) disable iff (reset)
        (state == SRXO_IDLE) |=> !fifoRead)
        else $error("fifo read without selection");

    // ======================================================
    // bit placement checks
    // ======================================================
    raw10_map_a: assert property (
        @(posedge clock) disable iff (reset)
        (srcValid && mode == SRXO_RAW10) |=> rx_char_bus == $past(srcRaw[BUS_W-1:0]))
        else $error("raw 10 bit order wrong");
    raw12_pins_a: assert property (
        @(posedge clock) disable iff (reset)
        (srcValid && mode == SRXO_RAW12) |=>
        rx_command_bits == {$past(srcRaw[RAW_B10]), $past(srcRaw[RAW_B11])})
        else $error("raw 12 bit pin order wrong");
    first_bit_a: assert property (
        @(posedge clock) disable iff (reset)
        (srcValid && !coded) |=> rx_char_bus[0] == $past(srcRaw[0]))
        else $error("first bit not at position zero");
    enc8_cmd_a: assert property (
        @(posedge clock) disable iff (reset)
        (fifoValid && mode == SRXO_ENC8 && fifoIsCmd) |=>
        rx_char_bus[BUS_CMD3] == $past(fifoCmd[3]) &&
        rx_char_bus[BUS_CMD2] == $past(fifoCmd[CMD_HI_LSB]) &&
        rx_command_bits == $past(fifoCmd[1:0]))
        else $error("8 bit command placement wrong");
    enc8_data_a: assert property (
        @(posedge clock) disable iff (reset)
        (fifoValid && mode == SRXO_ENC8 && !fifoIsCmd) |=>
        rx_char_bus[DATA8_W-1:0] == $past(fifoData[DATA8_W-1:0]))
        else $error("8 bit data placement wrong");
    enc10_data_a: assert property (
        @(posedge clock) disable iff (reset)
        (fifoValid && mode == SRXO_ENC10 && !fifoIsCmd) |=> rx_char_bus == $past(fifoData))
        else $error("10 bit data placement wrong");
    enc10_cmd_a: assert property (
        @(posedge clock) disable iff (reset)
        (fifoValid && mode == SRXO_ENC10 && fifoIsCmd) |=>
        rx_command_bits == $past(fifoCmd[1:0]))
        else $error("10 bit command placement wrong");

    // ======================================================
    // output register checks
    // ======================================================
    pass_src_a: assert property (
        @(posedge clock) disable iff (reset)
        (passThrough && deserValid) |=> charValid)
        else $error("bypassed character dropped");
    pass_data_a: assert property (
        @(posedge clock) disable iff (reset)
        (passThrough && deserValid) |=>
        rx_char_bus == $past(deserRaw[BUS_W-1:0]))
        else $error("bypassed character altered");
    pass_no_read_a: assert property (
        @(posedge clock) disable iff (reset)
        passThrough |=> !fifoRead)
        else $error("fifo read in passthrough");
    bus_hold_a: assert property (
        @(posedge clock) disable iff (reset)
        !srcValid |=> $stable(rx_char_bus))
        else $error("output bus changed without a character");
    raw_flags_a: assert property (
        @(posedge clock) disable iff (reset)
        (srcValid && !coded) |=> !rx_cmd_data_flag && !code_violation)
        else $error("flags driven in bypass");
    coded_flags_a: assert property (
        @(posedge clock) disable iff (reset)
        (srcValid && coded) |=>
        rx_cmd_data_flag == $past(fifoIsCmd) && code_violation == $past(fifoViolation))
        else $error("flags not carried with character");

    // ======================================================
    // framing checks
    // ======================================================
    align_a: assert property (
        @(posedge clock) disable iff (reset)
        !frame_align_enable |=> !aligned)
        else $error("aligned without framing");
    no_sync_a: assert property (
        @(posedge clock) disable iff (reset)
        !syncSeen |=> !aligned)
        else $error("aligned without sync");
    align_on_a: assert property (
        @(posedge clock) disable iff (reset)
        (frame_align_enable && syncSeen) |=> aligned)
        else $error("not aligned with framing and sync");

    // ======================================================
    // main scenarios
    // ======================================================
    read_cv: cover property (@(posedge clock) disable iff (reset)
        state == SRXO_ADDRESSED ##1 state == SRXO_READING);
    raw12_cv: cover property (@(posedge clock) disable iff (reset)
        srcValid && mode == SRXO_RAW12);
    cmd8_cv: cover property (@(posedge clock) disable iff (reset)
        fifoValid && mode == SRXO_ENC8 && fifoIsCmd);
    pass_cv: cover property (@(posedge clock) disable iff (reset)
        passThrough && deserValid);
    align_cv: cover property (@(posedge clock) disable iff (reset)
        frame_align_enable && syncSeen);
endmodule

//--- tb/serial_rx_output_port_tb_top.sv
`timescale 1ns/1ps
//==========================================================
// bench top
//==========================================================
module serial_rx_output_port_tb_top;
    import srxo_pkg::*;
    logic clock = 0, reset = 1, start = 0, stray = 0;
    logic cbN = 1, wSel = 1, fBy = 0, fEn = 0, sync = 0;
    logic fV = 0, fIsC = 0, fViol = 0, dV = 0;
    logic [11:0] fRaw = 12'h000, dRaw = 12'h000;
    logic [9:0] fData = 10'h000, bus, lastChar;
    logic [3:0] fCmd = 4'h0;
    logic [1:0] pins;
    logic csN, strobe, fRd, flag, viol, oeN, cV, algn;
    int fails = 0, n_tests = 0, cyc = 0;
    always #2 clock = ~clock;
    srxo_host srxo_host_inst (.clock(clock), .reset(reset), .start(start), .stray(stray),
        .rx_char_bus(bus), .charValid(cV), .chipSelect_n(csN), .rx_read_strobe(strobe),
        .lastChar(lastChar));
    srxo_port srxo_port_inst (.clock(clock), .reset(reset), .chipSelect_n(csN),
        .rx_read_strobe(strobe), .codec_bypass_n(cbN), .char_width_sel(wSel),
        .fifo_bypass_sel(fBy), .frame_align_enable(fEn), .syncSeen(sync), .fifoValid(fV),
        .fifoRaw(fRaw), .fifoData(fData), .fifoCmd(fCmd), .fifoIsCmd(fIsC),
        .fifoViolation(fViol), .deserValid(dV), .deserRaw(dRaw), .fifoRead(fRd),
        .rx_char_bus(bus), .rx_command_bits(pins), .rx_cmd_data_flag(flag),
        .code_violation(viol), .busOe_n(oeN), .charValid(cV), .aligned(algn));
    // compare, count and report
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // one character from the fifo, the deserializer offers the inverse
    task push(input logic [11:0] r, input logic [9:0] d, input logic [3:0] c, input logic k);
        fV = 1; fRaw = r; fData = d; fCmd = c; fIsC = k; fViol = k; dV = 1; dRaw = ~r;
        tick(1);
        fV = 0; dV = 0;
    endtask
    // expected pins and bus per mode, with the mask of defined bits
    function automatic logic [23:0] ex(int m, logic [11:0] r, logic [9:0] d,
        logic [3:0] c, logic k);
        case (m)
            0: ex = k ? {12'hF00, c[1:0], c[2], c[3], 8'h00} : {12'hFFF, 4'h0, d[7:0]};
            1: ex = k ? {12'hC00, c[1:0], 10'h000} : {12'h3FF, 2'h0, d};
            2: ex = {12'h3FF, 2'h0, r[9:0]};
            default: ex = {12'hFFF, r[10], r[11], r[9:0]};
        endcase
    endfunction
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        logic [23:0] e;
        logic [11:0] r;
        tick(12);
        reset = 0;
        stray = 1;
        tick(4);
        chk({11'h0, oeN}, 12'h001);
        chk({11'h0, fRd}, 12'h000);
        stray = 0;
        start = 1;
        tick(2);
        chk({11'h0, oeN}, 12'h001);
        tick(1);
        chk({10'h0, oeN, fRd}, 12'h001);
        $display("test select and strobe done");
        for (int m = 0; m < 4; m++) begin
            cbN = (m < 2);
            wSel = !m[0];
            tick(1);
            for (int k = 0; k < 2; k++) begin
                r = 12'hA5C ^ (12'h111 * m) ^ k;
                e = ex(m, r, 10'h2B3 ^ k, 4'hD ^ m, k[0]);
                push(r, 10'h2B3 ^ k, 4'hD ^ m, k[0]);
                chk({pins, bus} & e[23:12], e[11:0]);
                chk({11'h0, cV}, 12'h001);
                if (m < 2) chk({10'h0, flag, viol}, {10'h0, k[0], k[0]});
                else chk({10'h0, flag, viol}, 12'h000);
                tick(1);
            end
        end
        $display("test bit placement done");
        fBy = 1;
        tick(1);
        push(12'h3C6, 10'h155, 4'h0, 1'b0);
        chk({pins, bus}, {12'hC39});
        chk({11'h0, fRd}, 12'h000);
        tick(2);
        chk({11'h0, cV}, 12'h000);
        chk({2'h0, bus}, 12'h039);
        chk({2'h0, lastChar}, 12'h039);
        $display("test passthrough done");
        for (int j = 0; j < 4; j++) begin
            fEn = j[1];
            sync = j[0];
            tick(2);
            chk({11'h0, algn}, {11'h0, j == 3});
        end
        $display("test framing done");
        end_sim();
    end
endmodule

//--- tb/srxo_host.sv
`timescale 1ns/1ps
//==========================================================
// host model: addresses the port and reads characters
//==========================================================
module srxo_host (
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic stray,
    input wire logic [9:0] rx_char_bus,
    input wire logic charValid,
    output logic chipSelect_n,
    output logic rx_read_strobe,
    output logic [9:0] lastChar
);
    // select first, strobe in the next cycle, strays strobe without select
    // controls are sampled at the edge and driven 1 ns after it
    always @(posedge clock) begin
        if (reset || !start) begin
            chipSelect_n <= #1 1'h1;
            rx_read_strobe <= #1 stray;
        end else begin
            chipSelect_n <= #1 1'h0;
            rx_read_strobe <= #1 !chipSelect_n;
        end
    end
    // host keeps each character for its own framing and decoding
    always @(posedge clock) begin
        if (charValid) begin
            lastChar <= rx_char_bus;
        end
    end
endmodule
